// ===== rtl/isd_pkg.sv
`default_nettype none
package isd_pkg;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_SECOND_ADDR = 8'h9E;
    localparam logic [7:0] IDX_STATUS      = 8'hEC;
    localparam logic [7:0] IDX_FIRST_ADDR  = 8'hED;
    localparam logic [7:0] IDX_DATA        = 8'hEE;
    localparam logic [7:0] IDX_CONTROL     = 8'hEF;
    localparam logic [7:0] IDX_DEBUG_ADDR  = 8'hF0;

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ADDR    = 8'h00;
    localparam logic [7:0] RST_DATA    = 8'h00;
    localparam logic [3:0] RST_CONTROL = 4'h0;
    localparam logic [6:0] RST_DEBUG   = 7'h00;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int ST_WAKE   = 7;
    localparam int ST_MATCH  = 6;
    localparam int ST_STOP   = 5;
    localparam int ST_RSTART = 4;
    localparam int ST_NACK   = 0;
    localparam int ADDR_EN   = 7;
    localparam int CT_STRETCH = 0;
    localparam int CT_FILTER  = 1;
    localparam int CT_MATCHIE = 2;
    localparam int CT_DEBUGEN = 3;
    localparam int CT_WHICH   = 7;

    // ------------------------------------------------------------------
    // Bit counts per byte on the wire.
    // ------------------------------------------------------------------
    localparam logic [3:0] BIT_ACK  = 4'h8;
    localparam logic [3:0] BIT_DONE = 4'h9;

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RX, ST_TX, ST_WAIT} isd_state_type;

    typedef struct packed {
        logic scl;
        logic sda;
    } isd_line_type;

endpackage
`default_nettype wire

// ===== rtl/isd_slave.sv
// Functional notes
// - First address match sets sticky match flag.
// - STOP sets sticky stop flag.
// - Repeated START sets sticky restart flag.
// - Transmit-empty flag set on load, cleared by write.
// - Receive-full flag set on byte, cleared by read.
// - First-byte indicator until second byte arrives.
// - Master NACK in transmit sets nack bit.
// - After NACK, resend previous byte next transfer.
// - Master ACK clears nack; software may clear.
// - Status writes clear wake, match, stop, restart, nack.
// - Address register: bit 7 enable, low seven address.
// - Second address matched too; indicator shows which.
// - Data read gives received byte; write queues transmit.
// - Debug enable allows debug address match interrupt.
// - Receive shifts bytes, flags each readable byte.
// - Receive overrun: NACK, or stretch clock when enabled.
// - Stretch ends when software clears receive flag.
// - Match in transmit loads and shifts preloaded byte.
// - Empty buffer with stretching holds clock low.
// - Empty buffer without stretching reloads old byte.
// - Master NACK ends data; release data line.
// - Spike filter removes pulses shorter than three cycles when enabled.
`timescale 1ns/1ps
`default_nettype none
module isd_slave (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic [9:0] avs_address,
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0] avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic            avs_waitrequest,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe_n,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    output logic            match_irq,
    output logic            debug_irq
);

    // ------------------------------------------------------------------
    // Bus slave.
    // ------------------------------------------------------------------
    logic [7:0] first_slave_address;
    logic [7:0] second_slave_address;
    logic [7:0] slave_data_buffer;
    logic [7:0] tx_data;
    logic [3:0] control;
    logic [6:0] debug_address_register;
    logic       address_wakeup_flag, address_match_flag, stop_seen_flag;
    logic       repeated_start_flag, transmit_buffer_empty_flag;
    logic       receive_buffer_full_flag, first_byte_indicator, nack_flag;
    logic       which_address_matched;

    wire [7:0] index      = avs_address[9:2];
    wire       access     = (avs_read | avs_write) & ~avs_waitrequest;
    wire       wr_low     = access & avs_write & avs_byteenable[0];
    wire [7:0] wdata      = avs_writedata[7:0];
    wire       status_wr  = wr_low & (index == isd_pkg::IDX_STATUS);
    wire       data_write = wr_low & (index == isd_pkg::IDX_DATA);
    wire       data_read  = access & avs_read & (index == isd_pkg::IDX_DATA);
    wire       clr_wake   = status_wr & wdata[isd_pkg::ST_WAKE];
    wire       clr_match  = status_wr & wdata[isd_pkg::ST_MATCH];
    wire       clr_stop   = status_wr & wdata[isd_pkg::ST_STOP];
    wire       clr_rstart = status_wr & wdata[isd_pkg::ST_RSTART];
    wire       clr_nack   = status_wr & wdata[isd_pkg::ST_NACK];
    wire       stretch_enable         = control[isd_pkg::CT_STRETCH];
    wire       spike_filter_enable    = control[isd_pkg::CT_FILTER];
    wire       match_interrupt_enable = control[isd_pkg::CT_MATCHIE];
    wire       debug_port_enable      = control[isd_pkg::CT_DEBUGEN];
    wire [7:0] status_view = {address_wakeup_flag, address_match_flag, stop_seen_flag,
                              repeated_start_flag, transmit_buffer_empty_flag,
                              receive_buffer_full_flag, first_byte_indicator, nack_flag};
    wire [7:0] control_view = {which_address_matched, 3'h0, control};
    wire [7:0] read_mux =
        (index == isd_pkg::IDX_SECOND_ADDR) ? second_slave_address :
        (index == isd_pkg::IDX_STATUS)      ? status_view :
        (index == isd_pkg::IDX_FIRST_ADDR)  ? first_slave_address :
        (index == isd_pkg::IDX_DATA)        ? slave_data_buffer :
        (index == isd_pkg::IDX_CONTROL)     ? control_view :
        (index == isd_pkg::IDX_DEBUG_ADDR)  ? {1'b0, debug_address_register} : 8'h00;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end
        else
        begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            avs_readdata    <= {24'h00_0000, read_mux};
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            first_slave_address    <= isd_pkg::RST_ADDR;
            second_slave_address   <= isd_pkg::RST_ADDR;
            control                <= isd_pkg::RST_CONTROL;
            debug_address_register <= isd_pkg::RST_DEBUG;
            tx_data                <= isd_pkg::RST_DATA;
        end
        else if (wr_low)
        begin
            if (index == isd_pkg::IDX_FIRST_ADDR)
                first_slave_address <= wdata;
            if (index == isd_pkg::IDX_SECOND_ADDR)
                second_slave_address <= wdata;
            if (index == isd_pkg::IDX_CONTROL)
                control <= wdata[3:0];
            if (index == isd_pkg::IDX_DEBUG_ADDR)
                debug_address_register <= wdata[6:0];
            if (index == isd_pkg::IDX_DATA)
                tx_data <= wdata;
        end
    end

    // ------------------------------------------------------------------
    // Line sampling and spike filter.
    // ------------------------------------------------------------------
    isd_pkg::isd_line_type sync1, sync2, sync3, sync4, line, line_prev;

    wire agree   = (sync2 == sync3);
    wire steady  = agree & (sync3 == sync4);
    wire take    = spike_filter_enable ? steady : agree;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            sync1     <= '1;
            sync2     <= '1;
            sync3     <= '1;
            sync4     <= '1;
            line      <= '1;
            line_prev <= '1;
        end
        else
        begin
            sync1     <= '{scl: scl_in, sda: sda_in};
            sync2     <= sync1;
            sync3     <= sync2;
            sync4     <= sync3;
            line      <= take ? sync3 : line;
            line_prev <= line;
        end
    end

    wire scl_rise   = line.scl & ~line_prev.scl;
    wire scl_fall   = ~line.scl & line_prev.scl;
    wire start_cond = line.scl & line_prev.scl & line_prev.sda & ~line.sda;
    wire stop_cond  = line.scl & line_prev.scl & ~line_prev.sda & line.sda;

    // ------------------------------------------------------------------
    // Bus protocol.
    // ------------------------------------------------------------------
    isd_pkg::isd_state_type state;
    logic [3:0] bit_count;
    logic [7:0] shift_reg;
    logic [7:0] last_tx;
    logic       resend;
    logic       second_pending;

    wire       scl_held = ~scl_oe_n;
    wire [6:0] rx_addr  = shift_reg[7:1];
    wire       hit1 = first_slave_address[isd_pkg::ADDR_EN]
                      & (rx_addr == first_slave_address[6:0]);
    wire       hit2 = second_slave_address[isd_pkg::ADDR_EN]
                      & (rx_addr == second_slave_address[6:0]);
    wire       hitd = debug_port_enable & (rx_addr == debug_address_register);
    wire       addr_end = scl_fall & (state == isd_pkg::ST_ADDR) & (bit_count == isd_pkg::BIT_ACK);
    wire       rx_end   = scl_fall & (state == isd_pkg::ST_RX) & (bit_count == isd_pkg::BIT_ACK);
    wire       rx_free  = scl_held & (state == isd_pkg::ST_RX) & ~receive_buffer_full_flag;
    wire       tx_free  = scl_held & (state == isd_pkg::ST_TX) & ~transmit_buffer_empty_flag;
    wire       master_bit = scl_rise & (state == isd_pkg::ST_TX) & (bit_count == isd_pkg::BIT_ACK);
    wire [7:0] tx_source  = resend ? last_tx : tx_data;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state                      <= isd_pkg::ST_IDLE;
            bit_count                  <= 4'h0;
            shift_reg                  <= 8'h00;
            last_tx                    <= 8'h00;
            resend                     <= 1'b0;
            second_pending             <= 1'b0;
            slave_data_buffer          <= isd_pkg::RST_DATA;
            address_wakeup_flag        <= 1'b0;
            address_match_flag         <= 1'b0;
            stop_seen_flag             <= 1'b0;
            repeated_start_flag        <= 1'b0;
            transmit_buffer_empty_flag <= 1'b0;
            receive_buffer_full_flag   <= 1'b0;
            first_byte_indicator       <= 1'b0;
            nack_flag                  <= 1'b0;
            which_address_matched      <= 1'b0;
            scl_oe_n                   <= 1'b1;
            sda_oe_n                   <= 1'b1;
            scl_out                    <= 1'b0;
            sda_out                    <= 1'b0;
            debug_irq                  <= 1'b0;
            match_irq                  <= 1'b0;
        end
        else
        begin
            // Software clears come first so that a same-cycle set wins.
            if (clr_wake)
                address_wakeup_flag <= 1'b0;
            if (clr_match)
            begin
                address_match_flag    <= 1'b0;
                which_address_matched <= 1'b0;
            end
            if (clr_stop)
                stop_seen_flag <= 1'b0;
            if (clr_rstart)
                repeated_start_flag <= 1'b0;
            if (clr_nack)
                nack_flag <= 1'b0;
            if (data_write)
                transmit_buffer_empty_flag <= 1'b0;
            if (data_read)
                receive_buffer_full_flag <= 1'b0;
            debug_irq <= 1'b0;
            match_irq <= address_match_flag & match_interrupt_enable;

            if (stop_cond)
            begin
                stop_seen_flag <= 1'b1;
                state          <= isd_pkg::ST_IDLE;
                scl_oe_n       <= 1'b1;
                sda_oe_n       <= 1'b1;
            end
            else if (start_cond)
            begin
                if (state != isd_pkg::ST_IDLE)
                    repeated_start_flag <= 1'b1;
                state     <= isd_pkg::ST_ADDR;
                bit_count <= 4'h0;
                scl_oe_n  <= 1'b1;
                sda_oe_n  <= 1'b1;
            end
            else if (rx_free)
            begin
                slave_data_buffer        <= shift_reg;
                receive_buffer_full_flag <= 1'b1;
                first_byte_indicator     <= second_pending;
                second_pending           <= 1'b0;
                sda_oe_n                 <= 1'b0;
                scl_oe_n                 <= 1'b1;
            end
            else if (tx_free)
            begin
                shift_reg                  <= tx_data;
                last_tx                    <= tx_data;
                transmit_buffer_empty_flag <= 1'b1;
                sda_oe_n                   <= tx_data[7];
                bit_count                  <= 4'h0;
                scl_oe_n                   <= 1'b1;
            end
            else if (master_bit)
            begin
                if (line.sda)
                begin
                    nack_flag <= 1'b1;
                    resend    <= 1'b1;
                    state     <= isd_pkg::ST_WAIT;
                    sda_oe_n  <= 1'b1;
                end
                else
                begin
                    nack_flag <= 1'b0;
                    bit_count <= isd_pkg::BIT_DONE;
                end
            end
            else if (scl_rise && bit_count < isd_pkg::BIT_ACK)
            begin
                shift_reg <= (state == isd_pkg::ST_TX) ? shift_reg
                                                       : {shift_reg[6:0], line.sda};
                bit_count <= bit_count + 4'h1;
            end
            else if (scl_rise)
                bit_count <= isd_pkg::BIT_DONE;
            else if (addr_end)
            begin
                if (hit1 | hit2)
                begin
                    address_match_flag    <= 1'b1;
                    address_wakeup_flag   <= 1'b1;
                    which_address_matched <= ~hit1;
                    second_pending        <= 1'b1;
                    sda_oe_n              <= 1'b0;
                end
                else
                begin
                    debug_irq <= hitd;
                    state     <= isd_pkg::ST_WAIT;
                end
            end
            else if (rx_end)
            begin
                if (!receive_buffer_full_flag)
                begin
                    slave_data_buffer        <= shift_reg;
                    receive_buffer_full_flag <= 1'b1;
                    first_byte_indicator     <= second_pending;
                    second_pending           <= 1'b0;
                    sda_oe_n                 <= 1'b0;
                end
                else if (stretch_enable)
                    scl_oe_n <= 1'b0;
            end
            else if (scl_fall && bit_count == isd_pkg::BIT_DONE)
            begin
                bit_count <= 4'h0;
                sda_oe_n  <= 1'b1;
                if (state == isd_pkg::ST_ADDR && shift_reg[0])
                begin
                    state                      <= isd_pkg::ST_TX;
                    shift_reg                  <= tx_source;
                    last_tx                    <= tx_source;
                    resend                     <= 1'b0;
                    transmit_buffer_empty_flag <= 1'b1;
                    sda_oe_n                   <= tx_source[7];
                end
                else if (state == isd_pkg::ST_ADDR)
                    state <= isd_pkg::ST_RX;
                else if (state == isd_pkg::ST_TX)
                begin
                    if (!transmit_buffer_empty_flag)
                    begin
                        shift_reg                  <= tx_data;
                        last_tx                    <= tx_data;
                        transmit_buffer_empty_flag <= 1'b1;
                        sda_oe_n                   <= tx_data[7];
                    end
                    else if (stretch_enable)
                    begin
                        scl_oe_n  <= 1'b0;
                        bit_count <= isd_pkg::BIT_DONE;
                    end
                    else
                    begin
                        shift_reg <= last_tx;
                        nack_flag <= 1'b1;
                        sda_oe_n  <= last_tx[7];
                    end
                end
            end
            else if (scl_fall && state == isd_pkg::ST_TX)
                sda_oe_n <= (bit_count == isd_pkg::BIT_ACK) | shift_reg[3'h7 - bit_count[2:0]];
        end
    end

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    stop_flag_set_a: assert property (@(posedge clock) disable iff (reset)
        stop_cond |=> stop_seen_flag)
        else $error("stop flag not set after stop");
    restart_flag_set_a: assert property (@(posedge clock) disable iff (reset)
        start_cond && state != isd_pkg::ST_IDLE |=> repeated_start_flag)
        else $error("restart flag not set");
    match_first_a: assert property (@(posedge clock) disable iff (reset)
        addr_end && hit1 && !stop_cond && !start_cond
        |=> address_match_flag && !which_address_matched ##1 match_irq == match_interrupt_enable)
        else $error("first address match wrong");
    tx_empty_clear_a: assert property (@(posedge clock) disable iff (reset)
        $fell(transmit_buffer_empty_flag) |-> $past(data_write))
        else $error("transmit empty flag fell without write");
    rx_full_clear_a: assert property (@(posedge clock) disable iff (reset)
        $fell(receive_buffer_full_flag) |-> $past(data_read))
        else $error("receive full flag fell without read");
    rx_byte_load_a: assert property (@(posedge clock) disable iff (reset)
        $rose(receive_buffer_full_flag) |-> slave_data_buffer == $past(shift_reg))
        else $error("received byte not placed in data buffer");
    stretch_release_a: assert property (@(posedge clock) disable iff (reset)
        rx_free && !stop_cond && !start_cond |=> scl_oe_n && !sda_oe_n)
        else $error("clock not released after receive flag cleared");
    nack_ack_clear_a: assert property (@(posedge clock) disable iff (reset)
        master_bit && !line.sda && !stop_cond && !start_cond && !rx_free && !tx_free
        |=> !nack_flag)
        else $error("nack bit not cleared by ack");
    nack_release_a: assert property (@(posedge clock) disable iff (reset)
        master_bit && line.sda && !stop_cond && !start_cond && !rx_free && !tx_free
        |=> nack_flag && sda_oe_n && state == isd_pkg::ST_WAIT)
        else $error("data line not released after master nack");
    bus_answer_a: assert property (@(posedge clock) disable iff (reset)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle");

endmodule // isd_slave
`default_nettype wire

// ===== test/isd_master.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Bus master model.
// ------------------------------
module isd_master (
    input  wire logic clock,
    input  wire logic scl_w,
    input  wire logic sda_w,
    output logic      scl_m,
    output logic      sda_m
);
    initial
    begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Releases the clock and waits for four high cycles, so a stretch is honoured.
    task automatic rise();
        int k;
        k = 0;
        scl_m <= 1'b1;
        while (k < 4)
        begin
            hold(1);
            k = (scl_w === 1'b1) ? k + 1 : 0;
        end
    endtask
    task automatic start();
        sda_m <= 1'b1;
        hold(2);
        rise();
        sda_m <= 1'b0;
        hold(4);
        scl_m <= 1'b0;
        hold(2);
    endtask
    // Ends the frame after the final acknowledge or refusal.
    task automatic stop();
        sda_m <= 1'b0;
        hold(2);
        rise();
        sda_m <= 1'b1;
        hold(4);
    endtask
    // The low phase leaves room for the slave's sampled answer before the clock rises.
    task automatic bit_io(input logic b, output logic s);
        sda_m <= b;
        hold(4);
        rise();
        s = sda_w;
        scl_m <= 1'b0;
        hold(4);
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q,
                        output logic a);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ack, a);
    endtask
endmodule // isd_master
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Bench top.
// ------------------------------
module tb_top;
    logic        clock;
    logic        reset;
    logic [9:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        scl_oe_n;
    logic        sda_oe_n;
    logic        match_irq;
    logic        scl_m;
    logic        sda_m;
    wire         scl_w = scl_m & scl_oe_n;
    wire         sda_w = sda_m & sda_oe_n;
    logic [7:0]  q;
    logic        a;
    int          n_mismatch = 0;
    int          check_count = 0;
    isd_slave uut (.clock(clock), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .scl_in(scl_w), .scl_out(),
        .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(), .sda_oe_n(sda_oe_n),
        .match_irq(match_irq), .debug_irq());
    isd_master m (.clock(clock), .scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [7:0] r);
        @(posedge clock);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= ~w;
        do
        begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, idx, d, r);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] mk, input logic [7:0] e);
        logic [7:0] r;
        bus(1'b0, idx, 8'h00, r);
        chk($sformatf("reg %h", idx), e, r & mk);
    endtask
    task automatic t_regs();
        rd(8'h9E, 8'hFF, 8'h00);
        rd(8'hEC, 8'hFF, 8'h00);
        rd(8'h10, 8'hFF, 8'h00);
        wr(8'hED, 8'hAA);
        wr(8'h9E, 8'hB5);
        wr(8'hEF, 8'h04);
        rd(8'hED, 8'hFF, 8'hAA);
        $display("test regs done");
    endtask
    task automatic t_write();
        m.start();
        m.xfer(8'h54, 1'b1, q, a);
        chk("addr ack", 8'h00, {7'h0, a});
        m.xfer(8'h5C, 1'b1, q, a);
        rd(8'hEC, 8'hF6, 8'hC6);
        chk("irq", 8'h01, {7'h0, match_irq});
        rd(8'hEE, 8'hFF, 8'h5C);
        rd(8'hEC, 8'h04, 8'h00);
        m.xfer(8'hA1, 1'b1, q, a);
        rd(8'hEC, 8'h06, 8'h04);
        m.xfer(8'h11, 1'b1, q, a);
        chk("overrun ack", 8'h01, {7'h0, a});
        m.stop();
        rd(8'hEE, 8'hFF, 8'hA1);
        rd(8'hEC, 8'h20, 8'h20);
        wr(8'hEC, 8'hF1);
        rd(8'hEC, 8'hF1, 8'h00);
        chk("irq", 8'h00, {7'h0, match_irq});
        $display("test write done");
    endtask
    task automatic t_read();
        wr(8'hEE, 8'h96);
        m.start();
        m.xfer(8'h6B, 1'b1, q, a);
        chk("addr ack", 8'h00, {7'h0, a});
        rd(8'hEF, 8'h80, 8'h80);
        rd(8'hEC, 8'h08, 8'h08);
        m.xfer(8'hFF, 1'b0, q, a);
        chk("tx byte", 8'h96, q);
        m.xfer(8'hFF, 1'b1, q, a);
        chk("reload", 8'h96, q);
        rd(8'hEC, 8'h01, 8'h01);
        m.start();
        rd(8'hEC, 8'h10, 8'h10);
        m.xfer(8'h6B, 1'b1, q, a);
        wr(8'hEE, 8'h3C);
        rd(8'hEC, 8'h08, 8'h00);
        m.xfer(8'hFF, 1'b0, q, a);
        chk("resend", 8'h96, q);
        rd(8'hEC, 8'h01, 8'h00);
        m.xfer(8'hFF, 1'b1, q, a);
        chk("new byte", 8'h3C, q);
        m.stop();
        wr(8'hEC, 8'hF1);
        $display("test read done");
    endtask
    task automatic t_stretch();
        wr(8'hEF, 8'h07);
        m.start();
        m.xfer(8'h54, 1'b1, q, a);
        m.xfer(8'h71, 1'b1, q, a);
        fork
            m.xfer(8'h72, 1'b1, q, a);
            begin
                repeat (300) @(posedge clock);
                chk("scl held", 8'h00, {7'h0, scl_w});
                rd(8'hEE, 8'hFF, 8'h71);
            end
        join
        chk("ack", 8'h00, {7'h0, a});
        m.stop();
        rd(8'hEE, 8'hFF, 8'h72);
        $display("test stretch done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        tally_and_finish();
    end
    initial
    begin
        reset = 1'b1;
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        t_regs();
        t_write();
        t_read();
        t_stretch();
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
